/* rtl/acr_sequencer.sv */
`default_nettype none
module acr_sequencer
  import acr_pkg::*;
#(
  parameter int TICK_DIV = acr_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [acr_pkg::ADDR_W-1:0] addr_in,
  input wire logic [acr_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [acr_pkg::DATA_W-1:0] rd_data_out,
  // Protection stages: trips [3:0] and low-set starts [1:0]
  input wire logic [3:0] stage_trip_in,
  input wire logic [1:0] stage_start_in,
  input wire logic [2:0] fixed_inhibit_in,
  input wire logic [3:0] sel_inhibit_in,
  // Digital inputs
  input wire logic ext_init_in,
  input wire logic ext_inhibit_in,
  input wire logic ext_block_in,
  input wire logic breaker_closed_in,
  input wire logic reclose_inhibit_in,
  // Breaker and stage outputs
  output logic breaker_close_command_out,
  output logic [3:0] stage_block_out,
  output logic definite_trip_alarm_out,
  output logic reclose_failed_out,
  output logic lockout_out
);
  import acr_pkg::*;

  initial begin
    if (TICK_DIV < 1) $error("acr_sequencer: TICK_DIV must be at least 1");
  end

  // ---------------------------------------------------------------
  // Tick prescaler
  // ---------------------------------------------------------------
  logic [31:0] div_reg, div_next;  // Clock count within a tick
  logic tick_reg, tick_next;  // One-cycle tick enable

  // Every timer steps on the same tick, so settings are whole ticks
  always_comb begin
    tick_next = (div_reg == 32'(TICK_DIV - 1));
    div_next = tick_next ? 32'h0 : div_reg + 32'h1;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_reg <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  // ---------------------------------------------------------------
  // Settings registers
  // ---------------------------------------------------------------
  logic [1:0] shots_reg, shots_next;  // Shot count setting
  logic [TMR_W-1:0] dead_reg [3], dead_next [3];  // Per-shot dead times
  logic [TMR_W-1:0] reclaim_reg, reclaim_next;
  logic [TMR_W-1:0] cutout_reg, cutout_next;
  logic [TMR_W-1:0] close_t_reg, close_t_next;
  logic [7:0] init_sel_reg, init_sel_next;
  logic [7:0] inh_sel_reg, inh_sel_next;
  logic [7:0] shotblk_reg, shotblk_next;
  logic [7:0] stageblk_reg, stageblk_next;
  logic [DATA_W-1:0] rd_data_reg, rd_data_next;  // Read data, one cycle late
  logic [DATA_W-1:0] status_word;

  // Writes decode by offset; unmapped writes are dropped
  always_comb begin
    shots_next = shots_reg;
    dead_next = dead_reg;
    reclaim_next = reclaim_reg;
    cutout_next = cutout_reg;
    close_t_next = close_t_reg;
    init_sel_next = init_sel_reg;
    inh_sel_next = inh_sel_reg;
    shotblk_next = shotblk_reg;
    stageblk_next = stageblk_reg;
    if (wr_in) begin
      unique case (addr_in)
        OFS_CTRL: shots_next = wr_data_in[CTRL_SHOTS_LSB +: 2];
        OFS_DEAD1: dead_next[0] = wr_data_in[TMR_W-1:0];
        OFS_DEAD2: dead_next[1] = wr_data_in[TMR_W-1:0];
        OFS_DEAD3: dead_next[2] = wr_data_in[TMR_W-1:0];
        OFS_RECLAIM: reclaim_next = wr_data_in[TMR_W-1:0];
        OFS_CUTOUT: cutout_next = wr_data_in[TMR_W-1:0];
        OFS_CLOSE: close_t_next = wr_data_in[TMR_W-1:0];
        OFS_INIT_SEL: init_sel_next = wr_data_in[7:0];
        OFS_INH_SEL: inh_sel_next = wr_data_in[7:0];
        OFS_SHOTBLK: shotblk_next = wr_data_in[7:0];
        OFS_STAGEBLK: stageblk_next = wr_data_in[7:0];
        default: ;  // Status and unmapped: ignored
      endcase
    end
    // Reads: unmapped offsets answer zero
    rd_data_next = '0;
    if (rd_in) begin
      unique case (addr_in)
        OFS_CTRL: rd_data_next = DATA_W'(shots_reg);
        OFS_DEAD1: rd_data_next = DATA_W'(dead_reg[0]);
        OFS_DEAD2: rd_data_next = DATA_W'(dead_reg[1]);
        OFS_DEAD3: rd_data_next = DATA_W'(dead_reg[2]);
        OFS_RECLAIM: rd_data_next = DATA_W'(reclaim_reg);
        OFS_CUTOUT: rd_data_next = DATA_W'(cutout_reg);
        OFS_CLOSE: rd_data_next = DATA_W'(close_t_reg);
        OFS_INIT_SEL: rd_data_next = DATA_W'(init_sel_reg);
        OFS_INH_SEL: rd_data_next = DATA_W'(inh_sel_reg);
        OFS_SHOTBLK: rd_data_next = DATA_W'(shotblk_reg);
        OFS_STAGEBLK: rd_data_next = DATA_W'(stageblk_reg);
        OFS_STATUS: rd_data_next = status_word;
        default: rd_data_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shots_reg <= SHOTS_RST;
      dead_reg <= '{TIME_RST, TIME_RST, TIME_RST};
      reclaim_reg <= TIME_RST;
      cutout_reg <= TIME_RST;
      close_t_reg <= TIME_RST;
      init_sel_reg <= SEL_RST;
      inh_sel_reg <= SEL_RST;
      shotblk_reg <= SEL_RST;
      stageblk_reg <= SEL_RST;
      rd_data_reg <= '0;
    end else begin
      shots_reg <= shots_next;
      dead_reg <= dead_next;
      reclaim_reg <= reclaim_next;
      cutout_reg <= cutout_next;
      close_t_reg <= close_t_next;
      init_sel_reg <= init_sel_next;
      inh_sel_reg <= inh_sel_next;
      shotblk_reg <= shotblk_next;
      stageblk_reg <= stageblk_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // ---------------------------------------------------------------
  // Input conditions
  // ---------------------------------------------------------------
  logic init_now;  // Any selected initiation source
  logic inhibit_now;  // Any fixed, selected or external inhibit source
  logic block_now;  // Shot initiation blocking active
  acr_state_e state_reg, state_next;
  logic [1:0] shot_reg, shot_next;  // Current shot, 0 when none

  // Arc trip is only wired to the inhibit side, never here; starts count only in idle, to begin a sequence
  assign init_now = |(stage_trip_in & init_sel_reg[INIT_TRIP_LSB +: 4])
    | ((state_reg == ST_IDLE) && |(stage_start_in & init_sel_reg[INIT_START_LSB +: 2]))
    | (ext_init_in & init_sel_reg[INIT_EXT_BIT]);
  assign inhibit_now = |fixed_inhibit_in | |(sel_inhibit_in & inh_sel_reg[3:0]) | ext_inhibit_in;
  assign block_now = |(stage_trip_in & shotblk_reg[SHOTBLK_STAGE_LSB +: 4]) | ext_block_in;

  // First shot after cur that is enabled and not blocked, 0 when none
  function automatic logic [1:0] pick_shot(input logic [1:0] cur, input logic [1:0] count,
                                           input logic [2:0] mask, input logic blk);
    logic [1:0] res;
    res = 2'h0;
    for (int s = 3; s >= 1; s--) begin
      if (s > cur && s <= count && !(blk && mask[s-1])) res = 2'(s);
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Shot sequencer
  // ---------------------------------------------------------------
  logic close_reg, close_next;
  logic [3:0] blk_reg, blk_next;
  logic alarm_reg, alarm_next;
  logic failed_reg, failed_next;
  logic lock_reg, lock_next;
  logic dead_ld, close_ld, reclaim_ld, cutout_ld, alarm_ld, tmr_clr;
  logic [TMR_W-1:0] dead_val;
  logic [1:0] pick;
  logic dead_done, close_done, reclaim_done, cutout_done, alarm_done;

  always_comb begin
    state_next = state_reg;
    shot_next = shot_reg;
    close_next = close_reg;
    blk_next = blk_reg;
    alarm_next = alarm_reg;
    failed_next = failed_reg;
    dead_ld = 1'b0;
    close_ld = 1'b0;
    reclaim_ld = 1'b0;
    cutout_ld = 1'b0;
    alarm_ld = 1'b0;
    tmr_clr = 1'b0;
    pick = pick_shot(shot_reg, shots_reg, shotblk_reg[SHOTBLK_MASK_LSB +: 3], block_now);
    dead_val = dead_reg[(pick == 2'h0) ? 2'h0 : pick - 2'h1];
    if (cutout_done) blk_next = 4'h0;
    if (alarm_done) alarm_next = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (inhibit_now) begin
          state_next = ST_LOCKED;
        end else if (init_now && breaker_closed_in) begin
          if (pick != 2'h0) begin
            state_next = ST_DEAD;
            shot_next = pick;
            dead_ld = 1'b1;
          end else begin
            state_next = ST_LOCKED;
            alarm_next = 1'b1;
            alarm_ld = 1'b1;
          end
        end
      end
      ST_DEAD: begin
        if (inhibit_now) begin
          state_next = ST_LOCKED;
          tmr_clr = 1'b1;
        end else if (dead_done) begin
          if (reclose_inhibit_in || init_now) begin
            state_next = ST_LOCKED;
            failed_next = 1'b1;
          end else begin
            state_next = ST_CLOSING;
            close_next = 1'b1;
            close_ld = 1'b1;
            reclaim_ld = 1'b1;
            cutout_ld = 1'b1;
            blk_next = (shot_reg == 2'h1) ? stageblk_reg[3:0] : stageblk_reg[STAGEBLK_S23_LSB +: 4];
          end
        end
      end
      ST_CLOSING, ST_RECLAIM: begin
        if (inhibit_now) begin
          state_next = ST_LOCKED;
          close_next = 1'b0;
          tmr_clr = 1'b1;
        end else if (init_now) begin
          close_next = 1'b0;
          if (pick != 2'h0) begin
            state_next = ST_DEAD;
            shot_next = pick;
            dead_ld = 1'b1;
          end else begin
            state_next = ST_LOCKED;
            alarm_next = 1'b1;
            alarm_ld = 1'b1;
            tmr_clr = 1'b1;
          end
        end else if (state_reg == ST_CLOSING && breaker_closed_in) begin
          state_next = ST_RECLAIM;
          close_next = 1'b0;
        end else if (state_reg == ST_CLOSING && close_done) begin
          state_next = ST_LOCKED;
          close_next = 1'b0;
          failed_next = 1'b1;
          tmr_clr = 1'b1;
        end else if (state_reg == ST_RECLAIM && reclaim_done) begin
          state_next = ST_IDLE;
          shot_next = 2'h0;
        end
      end
      ST_LOCKED: begin
        // Reclaim restarts every cycle the cause stands, so it times from its removal
        if (inhibit_now || alarm_reg) begin
          reclaim_ld = 1'b1;
        end else if (reclaim_done) begin
          state_next = ST_IDLE;
          shot_next = 2'h0;
          failed_next = 1'b0;
        end
      end
      default: state_next = ST_IDLE;  // Illegal code recovers
    endcase
    if (state_reg != ST_LOCKED && state_next == ST_LOCKED) reclaim_ld = 1'b1;
    // Out of operation: everything returns to rest
    if (shots_reg == 2'h0) begin
      state_next = ST_IDLE;
      shot_next = 2'h0;
      close_next = 1'b0;
      blk_next = 4'h0;
      alarm_next = 1'b0;
      failed_next = 1'b0;
      tmr_clr = 1'b1;
      {dead_ld, close_ld, reclaim_ld, cutout_ld, alarm_ld} = 5'h00;
    end
    lock_next = (state_next == ST_LOCKED);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      shot_reg <= 2'h0;
      close_reg <= 1'b0;
      blk_reg <= 4'h0;
      alarm_reg <= 1'b0;
      failed_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shot_reg <= shot_next;
      close_reg <= close_next;
      blk_reg <= blk_next;
      alarm_reg <= alarm_next;
      failed_reg <= failed_next;
      lock_reg <= lock_next;
    end
  end

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  acr_timer #(.WIDTH(TMR_W)) u_dead (.clk_in(clk_in), .rst_in(rst_in), .tick_in(tick_reg), .load_in(dead_ld),
    .clear_in(tmr_clr), .value_in(dead_val), .busy_out(), .done_out(dead_done));
  acr_timer #(.WIDTH(TMR_W)) u_close (.clk_in(clk_in), .rst_in(rst_in), .tick_in(tick_reg),
    .load_in(close_ld), .clear_in(tmr_clr | ~close_reg), .value_in(close_t_reg), .busy_out(),
    .done_out(close_done));
  acr_timer #(.WIDTH(TMR_W)) u_reclaim (.clk_in(clk_in), .rst_in(rst_in), .tick_in(tick_reg),
    .load_in(reclaim_ld), .clear_in(tmr_clr), .value_in(reclaim_reg), .busy_out(), .done_out(reclaim_done));
  acr_timer #(.WIDTH(TMR_W)) u_cutout (.clk_in(clk_in), .rst_in(rst_in), .tick_in(tick_reg),
    .load_in(cutout_ld), .clear_in(1'b0), .value_in(cutout_reg), .busy_out(), .done_out(cutout_done));
  acr_timer #(.WIDTH(TMR_W)) u_alarm (.clk_in(clk_in), .rst_in(rst_in), .tick_in(tick_reg),
    .load_in(alarm_ld), .clear_in(1'b0), .value_in(TMR_W'(ALARM_TICKS)), .busy_out(), .done_out(alarm_done));

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign status_word = DATA_W'({close_reg, alarm_reg, failed_reg, lock_reg}) << STAT_FLAG_LSB
    | DATA_W'(shot_reg) << STAT_SHOT_LSB | DATA_W'(state_reg);
  assign rd_data_out = rd_data_reg;
  assign breaker_close_command_out = close_reg;
  assign stage_block_out = blk_reg;
  assign definite_trip_alarm_out = alarm_reg;
  assign reclose_failed_out = failed_reg;
  assign lockout_out = lock_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_disabled_idle: assert property (shots_reg == 2'h0 |=> state_reg == ST_IDLE)
    else $error("sequencer active while disabled");
  chk_inhibit_abort: assert property (inhibit_now && state_reg == ST_DEAD && shots_reg != 2'h0
    |=> state_reg == ST_LOCKED && !close_reg)
    else $error("inhibit did not abort shot");
  chk_open_refuse: assert property (state_reg == ST_IDLE && !breaker_closed_in |=> state_reg != ST_DEAD)
    else $error("shot started with breaker open");
  chk_close_issue: assert property (state_reg == ST_DEAD && dead_done && !inhibit_now && !init_now
    && !reclose_inhibit_in && shots_reg != 2'h0 |=> close_reg && state_reg == ST_CLOSING)
    else $error("no close after dead time");
  chk_recl_inhibit: assert property (state_reg == ST_DEAD && dead_done && reclose_inhibit_in && !inhibit_now
    && shots_reg != 2'h0 |=> failed_reg && !close_reg)
    else $error("reclose inhibit ignored");
  chk_close_end: assert property (close_reg && breaker_closed_in && !init_now |=> !close_reg)
    else $error("close command outlived breaker closed");
  chk_reclaim_idle: assert property (state_reg == ST_RECLAIM && reclaim_done && !init_now && !inhibit_now
    |=> state_reg == ST_IDLE && shot_reg == 2'h0)
    else $error("reclaim expiry did not reset");
  chk_cutout_clear: assert property (cutout_done && state_reg != ST_DEAD |=> blk_reg == 4'h0)
    else $error("blocking held after cutout");
  chk_alarm_lock: assert property ($rose(alarm_reg) |-> lock_reg)
    else $error("alarm without lockout");
  chk_alarm_len: assert property ($rose(alarm_reg) |-> alarm_reg [*8])
    else $error("alarm dropped early");
  chk_shot_range: assert property (shot_reg <= shots_reg || shots_reg == 2'h0)
    else $error("shot beyond setting");

  cov_full_reclose: cover property (state_reg == ST_CLOSING ##[1:1000] state_reg == ST_IDLE);
  cov_second_shot: cover property (state_reg == ST_DEAD && shot_reg == 2'h2);
  cov_definite_trip: cover property ($rose(alarm_reg));
  cov_close_failed: cover property ($rose(failed_reg));
endmodule
`default_nettype wire

/* common/acr_pkg.sv */
`default_nettype none
package acr_pkg;
  // ---------------------------------------------------------------
  // Clock and tick timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;  // 250 MHz system clock
  localparam int TICK_PERIOD_NS = 1000000;  // One sequencer tick is 1 ms
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;  // Prescaler default
  localparam int ALARM_TIME_MS = 1000;  // Definite trip alarm hold time
  localparam int ALARM_TICKS = (ALARM_TIME_MS * 1000000) / TICK_PERIOD_NS;
  localparam int TMR_W = 16;  // Width of every timer setting in ticks

  // ---------------------------------------------------------------
  // Register bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;  // Shot count setting
  localparam logic [ADDR_W-1:0] OFS_DEAD1 = 8'h04;  // Dead time shot 1
  localparam logic [ADDR_W-1:0] OFS_DEAD2 = 8'h08;  // Dead time shot 2
  localparam logic [ADDR_W-1:0] OFS_DEAD3 = 8'h0c;  // Dead time shot 3
  localparam logic [ADDR_W-1:0] OFS_RECLAIM = 8'h10;  // Reclaim time
  localparam logic [ADDR_W-1:0] OFS_CUTOUT = 8'h14;  // Cutout time
  localparam logic [ADDR_W-1:0] OFS_CLOSE = 8'h18;  // Close command duration
  localparam logic [ADDR_W-1:0] OFS_INIT_SEL = 8'h1c;  // Initiation sources
  localparam logic [ADDR_W-1:0] OFS_INH_SEL = 8'h20;  // Selectable inhibit sources
  localparam logic [ADDR_W-1:0] OFS_SHOTBLK = 8'h24;  // Shot initiation blocking
  localparam logic [ADDR_W-1:0] OFS_STAGEBLK = 8'h28;  // Stage blocking per shot
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h2c;  // Read-only state

  // ---------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_SHOTS_LSB = 0;  // [1:0] shot count setting
  localparam int INIT_TRIP_LSB = 0;  // [3:0] trip stages that initiate
  localparam int INIT_START_LSB = 4;  // [5:4] low-set start signals
  localparam int INIT_EXT_BIT = 6;  // External initiation enable
  localparam int SHOTBLK_STAGE_LSB = 0;  // [3:0] trip stages that block
  localparam int SHOTBLK_MASK_LSB = 4;  // [6:4] shots that may be blocked
  localparam int STAGEBLK_S23_LSB = 4;  // [7:4] shots 2 and 3, [3:0] shot 1
  localparam int STAT_SHOT_LSB = 8;  // [9:8] current shot number
  localparam int STAT_FLAG_LSB = 12;  // [15:12] close, alarm, failed, lockout
  localparam logic [1:0] SHOTS_RST = 2'h0;  // Disabled after reset
  localparam logic [TMR_W-1:0] TIME_RST = 16'h0064;  // 100 ticks
  localparam logic [7:0] SEL_RST = 8'h00;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DEAD = 5'b00010,
    ST_CLOSING = 5'b00100,
    ST_RECLAIM = 5'b01000,
    ST_LOCKED = 5'b10000
  } acr_state_e;
endpackage
`default_nettype wire

/* rtl/acr_timer.sv */
`default_nettype none
module acr_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic tick_in,
  input wire logic load_in,
  input wire logic clear_in,
  input wire logic [WIDTH-1:0] value_in,
  // Status
  output logic busy_out,
  output logic done_out
);
  // ---------------------------------------------------------------
  // Down counter, one step per tick
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] cnt_reg, cnt_next;  // Remaining ticks
  logic busy_reg, busy_next;  // Counting
  logic done_reg, done_next;  // One-cycle expiry pulse

  initial begin
    if (WIDTH < 2) $error("acr_timer: WIDTH too small");
  end

  // Next count; load wins over clear so a reload never gets lost
  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (load_in) begin
      cnt_next = value_in;
      busy_next = 1'b1;
    end else if (clear_in) begin
      busy_next = 1'b0;
    end else if (busy_reg && cnt_reg == '0) begin
      // A zero setting expires on the cycle after the load
      busy_next = 1'b0;
      done_next = 1'b1;
    end else if (busy_reg && tick_in) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Registers only
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy_out = busy_reg;
  assign done_out = done_reg;
endmodule
`default_nettype wire

/* tb/acr_bkr_model.sv */
`default_nettype none
module acr_bkr_model #(
  parameter int CLOSE_DLY = 8  // Mechanism travel time in clocks
) (
  // Clock
  input wire logic clk_in,
  // Commands
  input wire logic close_cmd_in,  // Close command from the sequencer
  input wire logic trip_in,  // Any protection trip opens the breaker
  input wire logic man_close_in,  // Operator close
  // Position contact only, no readiness status
  output logic closed_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;  // Clocks the close command has been held
  initial closed_out = 1'b0;
  // A trip wins over any close; a short close command never moves the contacts
  always @(posedge clk_in) begin
    cnt <= (close_cmd_in && !closed_out) ? cnt + 1 : 0;
    if (trip_in) begin
      closed_out <= 1'b0;
    end else if (man_close_in || cnt == CLOSE_DLY) begin
      closed_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
  import acr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, d;
  logic wr = 1'b0, rd = 1'b0, einit = 1'b0, einh = 1'b0, man = 1'b0, eblk = 1'b0, rinh = 1'b0;
  logic [3:0] trip = 4'h0, blk;
  logic bclosed, close, alarm, failed, lock;
  int err_count = 0, checked = 0;
  acr_sequencer #(.TICK_DIV(2)) acr_sequencer_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
    .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .stage_trip_in(trip),
    .stage_start_in(2'h0), .fixed_inhibit_in(3'h0), .sel_inhibit_in(4'h0), .ext_init_in(einit),
    .ext_inhibit_in(einh), .ext_block_in(eblk), .breaker_closed_in(bclosed),
    .reclose_inhibit_in(rinh), .breaker_close_command_out(close), .stage_block_out(blk),
    .definite_trip_alarm_out(alarm), .reclose_failed_out(failed), .lockout_out(lock));
  acr_bkr_model acr_bkr_model_i (.clk_in(clk_in), .close_cmd_in(close), .trip_in(|trip),
    .man_close_in(man), .closed_out(bclosed));
  // 250 MHz clock
  initial forever #2 clk_in = ~clk_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr <= a;
    wdat <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  // Poll the state field under a bounded count, then compare it
  task automatic wait_st(input logic [4:0] s, input int lim);
    int n;
    n = 0;
    do begin
      rd_reg(OFS_STATUS);
      n++;
    end while (d[4:0] !== s && n < lim);
    chk(d & 32'h1f, {27'h0, s});
  endtask
  // Two-cycle pulse on trips and on ext init, ext inhibit, manual close
  task automatic kick(input logic [3:0] t, input logic [2:0] x);
    @(posedge clk_in);
    trip <= t;
    {einit, einh, man} <= x;
    @(posedge clk_in);
    @(posedge clk_in);
    trip <= 4'h0;
    {einit, einh, man} <= 3'h0;
  endtask
  task automatic tally_and_finish;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #100000;
    err_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_reg(OFS_STATUS);
    chk(d, 32'h1);
    chk({27'h0, close, alarm, failed, lock, |blk}, 32'h0);
    wr_reg(OFS_INIT_SEL, 32'h41);
    kick(4'h0, 3'h1);
    kick(4'h1, 3'h0);
    wait_st(5'h01, 4);
    wr_reg(OFS_CTRL, 32'h2);
    wr_reg(OFS_DEAD1, 32'h8);
    wr_reg(OFS_DEAD2, 32'h8);
    wr_reg(OFS_RECLAIM, 32'h28);
    wr_reg(OFS_CUTOUT, 32'h6);
    wr_reg(OFS_CLOSE, 32'h14);
    wr_reg(OFS_INIT_SEL, 32'h41);
    wr_reg(OFS_STAGEBLK, 32'h52);
    kick(4'h1, 3'h0);
    wait_st(5'h01, 4);
    kick(4'h0, 3'h1);
    kick(4'h8, 3'h0);
    wait_st(5'h01, 4);
    kick(4'h0, 3'h1);
    kick(4'h1, 3'h0);
    wait_st(5'h02, 4);
    wait_st(5'h04, 20);
    chk({28'h0, blk}, 32'h2);
    wait_st(5'h08, 20);
    chk({31'h0, close}, 32'h0);
    kick(4'h1, 3'h0);
    wait_st(5'h02, 4);
    chk({30'h0, d[9:8]}, 32'h2);
    wait_st(5'h04, 20);
    chk({28'h0, blk}, 32'h5);
    wait_st(5'h01, 100);
    chk({30'h0, d[9:8]}, 32'h0);
    chk({28'h0, blk}, 32'h0);
    kick(4'h0, 3'h4);
    wait_st(5'h02, 4);
    kick(4'h0, 3'h2);
    wait_st(5'h10, 4);
    wait_st(5'h01, 200);
    wr_reg(OFS_CTRL, 32'h1);
    kick(4'h1, 3'h0);
    wait_st(5'h08, 40);
    kick(4'h1, 3'h0);
    wait_st(5'h10, 4);
    chk({30'h0, alarm, close}, 32'h2);
    wait_st(5'h01, 1500);
    chk({31'h0, alarm}, 32'h0);
    // Blocked shot 1 moves on to shot 2; held reclose inhibit fails it at dead-time end
    wr_reg(OFS_CTRL, 32'h2);
    wr_reg(OFS_SHOTBLK, 32'h10);
    kick(4'h0, 3'h1);
    rinh <= 1'b1;
    eblk <= 1'b1;
    kick(4'h1, 3'h0);
    eblk <= 1'b0;
    wait_st(5'h02, 4);
    chk({30'h0, d[9:8]}, 32'h2);
    wait_st(5'h10, 20);
    chk({29'h0, failed, close, lock}, 32'h5);
    rinh <= 1'b0;
    wait_st(5'h01, 100);
    chk({31'h0, failed}, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
